// ### dv/ptp_capture_port_config_tb.sv
// Self-checking bench for the PTP capture configuration block.
// Assumes the frame source model and an AHB-Lite master in tasks.
`default_nettype none

module ptp_capture_port_config_tb;
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////
  logic sys_clk, rst; // Clock and reset
  logic hsel, hwrite, hreadyout, hresp, irq; // Bus controls, interrupt
  logic [31:0] haddr, hwdata, hrdata; // Bus address and data
  logic [1:0] htrans; // Transfer type
  logic [2:0] hsize; // Transfer size
  logic [31:0] ptpTime; // Time fed to the captures
  logic [3:0] evValid, evSync, evDelayReq; // Frame flags
  logic [3:0][47:0] evDa; // Destinations
  logic [3:0][15:0] evSeqId, evSrcId; // Frame ids
  int bad_count, check_count; // Mismatches, comparisons

  ptp_capture_port_config dut_u (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ptpTime(ptpTime), .evValid(evValid), .evDa(evDa), .evSync(evSync),
    .evDelayReq(evDelayReq), .evSeqId(evSeqId), .evSrcId(evSrcId),
    .irq(irq));

  ptp_frame_source frame_u (.sys_clk(sys_clk), .evValid(evValid),
    .evDa(evDa), .evSync(evSync), .evDelayReq(evDelayReq),
    .evSeqId(evSeqId), .evSrcId(evSrcId));

  ////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Compare one word
  task automatic check(input string name, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : check

  // Bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      $display("BAD hready exp 1 got %b", hreadyout);
      test_done();
    end
  endtask : wait_ready

  // One single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("hresp", 32'h0, 32'(hresp));
  endtask : ahb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic expect_reg(input string n, input logic [11:0] a,
                            input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(n, exp, x);
  endtask : expect_reg

  // Status compare, then clear of every pending bit
  task automatic expect_sts(input string n, input logic [31:0] exp);
    expect_reg(n, ptp_capture_pkg::ADDR_IRQ_STS, exp);
    wr(ptp_capture_pkg::ADDR_IRQ_CLR, 32'hf);
  endtask : expect_sts

  // Frame with a known time at the capture edge
  task automatic frame(input int s, input logic [47:0] da,
                       input logic sync, input logic [15:0] seq,
                       input logic [31:0] t);
    ptpTime <= t;
    frame_u.send(s, da, sync, seq);
  endtask : frame

  ////////////////////////////////////////////////////////////////////////
  // Reset values, read-only and unmapped places
  task automatic test_reset();
    expect_reg("cfg", 12'h194, 32'h0043_4000);
    expect_reg("aux_lo", 12'h190, 32'h0);
    expect_reg("irq_en", ptp_capture_pkg::ADDR_IRQ_EN, 32'h0);
    expect_reg("unmapped", 12'h0fc, 32'h0);
    wr(12'h194, 32'hffff_ffff);
    expect_reg("cfg_bits", 12'h194, 32'h00ff_c000);
    wr(ptp_capture_pkg::ADDR_IRQ_STS, 32'hf);
    expect_sts("sts_ro", 32'h0);
    check("irq_idle", 32'h0, 32'(irq));
    $display("test_reset done");
  endtask : test_reset

  // Each port 1 address enable against each address
  task automatic test_addr();
    logic [47:0] da [6];
    int e, a;
    logic [31:0] ok;
    da = '{ptp_capture_pkg::PRI_ADDR, ptp_capture_pkg::ALT_A_ADDR,
      ptp_capture_pkg::ALT_B_ADDR, ptp_capture_pkg::ALT_C_ADDR,
      48'h0a1b_2c3d_4e5f, 48'h0000_2c3d_4e5f};
    wr(ptp_capture_pkg::ADDR_AUX_HI, 32'hffff_0a1b);
    wr(ptp_capture_pkg::ADDR_AUX_LO, 32'h2c3d_4e5f);
    expect_reg("aux_hi", 12'h18c, 32'h0000_0a1b);
    for (int i = 0; i < 30; i++) begin
      e = i / 6;
      a = i % 6;
      wr(12'h194, 32'h0040_0000 >> e);
      frame(0, da[a], 1'b1, 16'(i), 32'(i));
      ok = 32'(a == e);
      expect_sts("hit", ok);
    end
    $display("test_addr done");
  endtask : test_addr

  // Role, direction and message type per slot
  task automatic test_role();
    logic hit;
    logic [31:0] x;
    for (int i = 0; i < 16; i++) begin
      // i[3] master, i[2:1] slot, i[0] Delay_Req
      wr(12'h194, 32'h0043_4000 | (i[3] ? 32'h0080_8000 : 32'h0));
      hit = ~(i[3] ^ i[1] ^ i[0]);
      frame(i[2:1], ptp_capture_pkg::PRI_ADDR, ~i[0], 16'(i), 32'(i));
      x = 32'(hit) << i[2:1];
      expect_sts("role", x);
    end
    wr(12'h194, 32'h0040_0000);
    frame(2, ptp_capture_pkg::PRI_ADDR, 1'b1, 16'h7, 32'h7);
    expect_sts("host_pri", 32'h0);
    $display("test_role done");
  endtask : test_role

  // Overwrite lock on port 1 receive and transmit, then reopening
  task automatic test_lock();
    logic [11:0] c;
    logic [31:0] t;
    for (int i = 0; i < 4; i++) begin
      // i[1] slot, i[0] lock on
      c = 12'h1b0 + (i[1] ? 12'h8 : 12'h0);
      wr(12'h194, 32'h0040_0000 | (32'(i[0]) << (17 - i[1])));
      frame(i[1], ptp_capture_pkg::PRI_ADDR, ~i[1], 16'h11, 32'h1000_0001);
      frame(i[1], ptp_capture_pkg::PRI_ADDR, ~i[1], 16'h22, 32'h2000_0002);
      t = i[0] ? 32'h1000_0001 : 32'h2000_0002;
      expect_reg("lock_time", c, t);
      t = i[0] ? 32'h0011_ffee : 32'h0022_ffdd;
      expect_reg("lock_tag", c + 12'h4, t);
      expect_sts("lock_pend", 32'h1 << i[1]);
      frame(i[1], ptp_capture_pkg::PRI_ADDR, ~i[1], 16'h33, 32'h3000_0003);
      expect_reg("reopen", c, 32'h3000_0003);
      wr(ptp_capture_pkg::ADDR_IRQ_CLR, 32'hf);
    end
    // Clear and a new locked capture meet at one edge: capture wins
    wr(12'h194, 32'h0043_4000);
    frame(0, ptp_capture_pkg::PRI_ADDR, 1'b1, 16'h44, 32'h4000_0004);
    fork
      wr(ptp_capture_pkg::ADDR_IRQ_CLR, 32'h1);
      begin
        @(posedge sys_clk);
        frame(0, ptp_capture_pkg::PRI_ADDR, 1'b1, 16'h55, 32'h5000_0005);
      end
    join
    expect_reg("race_time", 12'h1b0, 32'h5000_0005);
    expect_reg("race_tag", 12'h1b4, 32'h0055_ffaa);
    expect_sts("race_pend", 32'h1);
    $display("test_lock done");
  endtask : test_lock

  // Interrupt raised, masked, unmasked and cleared
  task automatic test_irq();
    wr(12'h194, 32'h0043_4000);
    wr(ptp_capture_pkg::ADDR_IRQ_EN, 32'h1);
    expect_reg("irq_en", ptp_capture_pkg::ADDR_IRQ_EN, 32'h1);
    frame(0, ptp_capture_pkg::PRI_ADDR, 1'b1, 16'h5, 32'h5);
    repeat (2) @(posedge sys_clk);
    check("irq_set", 32'h1, 32'(irq));
    wr(ptp_capture_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge sys_clk);
    check("irq_mask", 32'h0, 32'(irq));
    wr(ptp_capture_pkg::ADDR_IRQ_EN, 32'h1);
    repeat (2) @(posedge sys_clk);
    check("irq_unmask", 32'h1, 32'(irq));
    wr(ptp_capture_pkg::ADDR_IRQ_CLR, 32'h1);
    repeat (2) @(posedge sys_clk);
    check("irq_clr", 32'h0, 32'(irq));
    $display("test_irq done");
  endtask : test_irq

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ptpTime = 32'h0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_addr();
    test_role();
    test_lock();
    test_irq();
    test_done();
  end

endmodule : ptp_capture_port_config_tb

`default_nettype wire

// ### dv/ptp_frame_source.sv
// Model of the port packet paths and fabric that feed frame events.
// Assumes one frame at a time, each launched just after a clock edge.
`default_nettype none

module ptp_frame_source (
  input wire logic sys_clk, // Block clock
  output logic [3:0] evValid, // Frame seen, per slot
  output logic [3:0][47:0] evDa, // Destination, per slot
  output logic [3:0] evSync, // Sync message, per slot
  output logic [3:0] evDelayReq, // Delay_Req message, per slot
  output logic [3:0][15:0] evSeqId, // Sequence ID, per slot
  output logic [3:0][15:0] evSrcId // Source identity, per slot
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////
  // Idle values at time zero
  initial begin
    evValid = 4'h0;
    evDa = '0;
    evSync = 4'h0;
    evDelayReq = 4'h0;
    evSeqId = '0;
    evSrcId = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame event of one cycle; source identity is the inverted seq
  task automatic send(input int slot, input logic [47:0] da,
                      input logic sync, input logic [15:0] seq);
    @(posedge sys_clk);
    evValid[slot] <= 1'b1;
    evDa[slot] <= da;
    evSync[slot] <= sync;
    evDelayReq[slot] <= ~sync;
    evSeqId[slot] <= seq;
    evSrcId[slot] <= ~seq;
    @(posedge sys_clk);
    // Fields go stale: show inverted values, never a held copy
    evValid <= 4'h0;
    evDa <= ~evDa;
    evSync <= ~evSync;
    evDelayReq <= ~evDelayReq;
    evSeqId <= ~evSeqId;
    evSrcId <= ~evSrcId;
  endtask : send

endmodule : ptp_frame_source

`default_nettype wire

// ### src/ptp_capture_filter.sv
// Decides whether a frame on one port and direction is a capture frame.
// Assumes the frame fields are valid in the cycle of evValid.
`default_nettype none

module ptp_capture_filter (
  ptp_capture_if.filt cap, // Frame in, hit out
  input wire logic priEn, // Primary address enable
  input wire logic [2:0] altEn, // Alternate address enables c..a
  input wire logic auxEn, // Auxiliary address enable
  input wire logic [47:0] auxAddr, // Auxiliary match address
  input wire logic master, // Clock master role
  input wire logic isTx // Direction is transmit
);

  logic addrHit; // Destination is an enabled PTP address
  logic roleHit; // Message type fits the role and direction

  ////////////////////////////////////////////////////////////////////////
  // Address and role match
  always_comb begin
    addrHit = (priEn && cap.da == ptp_capture_pkg::PRI_ADDR)
      || (altEn[0] && cap.da == ptp_capture_pkg::ALT_A_ADDR)
      || (altEn[1] && cap.da == ptp_capture_pkg::ALT_B_ADDR)
      || (altEn[2] && cap.da == ptp_capture_pkg::ALT_C_ADDR)
      || (auxEn && cap.da == auxAddr);
    // Master: Sync out, Delay_Req in; slave the reverse
    if (master) begin
      roleHit = isTx ? cap.isSync : cap.isDelayReq;
    end else begin
      roleHit = isTx ? cap.isDelayReq : cap.isSync;
    end
    cap.hit = cap.evValid && addrHit && roleHit;
  end

endmodule : ptp_capture_filter

`default_nettype wire

// ### src/ptp_capture_if.sv
// Carrier between the capture filter and the capture slot of one
// port and direction. Assumes both ends run on the same clock.
`default_nettype none

interface ptp_capture_if;
  logic evValid; // Frame seen this cycle
  logic [47:0] da; // Destination address
  logic isSync; // Frame is a Sync message
  logic isDelayReq; // Frame is a Delay_Req message
  logic [15:0] seqId; // Sequence ID of the frame
  logic [15:0] srcId; // Source identity of the frame
  logic hit; // Frame qualifies for capture

  modport filt(input evValid, da, isSync, isDelayReq, output hit);
  modport slot(input hit, seqId, srcId);
endinterface : ptp_capture_if

`default_nettype wire

// ### src/ptp_capture_pkg.sv
// Constants for the PTP capture configuration block: register offsets,
// field positions, reset values and the fixed PTP match addresses.
// Assumes one 32-bit register bus, word accesses only.
`default_nettype none

package ptp_capture_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Capture slots
  localparam int NUM_SLOTS = 4;
  localparam int SLOT_P1_RX = 0; // Port 1 receive
  localparam int SLOT_P1_TX = 1; // Port 1 transmit
  localparam int SLOT_HOST_RX = 2; // Fabric toward host MAC
  localparam int SLOT_HOST_TX = 3; // Host MAC into fabric
  localparam int SLOT_STRIDE = 8; // Bytes per capture slot

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets (decoded on the low twelve address bits)
  localparam logic [11:0] ADDR_AUX_HI = 12'h18c;
  localparam logic [11:0] ADDR_AUX_LO = 12'h190;
  localparam logic [11:0] ADDR_CONFIG = 12'h194;
  localparam logic [11:0] ADDR_IRQ_STS = 12'h1a0;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h1a4;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h1a8;
  localparam logic [11:0] ADDR_CAP_BASE = 12'h1b0;
  localparam logic [11:0] ADDR_CAP_END = 12'h1d0;

  ////////////////////////////////////////////////////////////////////////
  // Configuration register fields
  localparam int P1_MASTER_BIT = 23;
  localparam int P1_PRI_BIT = 22;
  localparam int P1_ALT_A_BIT = 21;
  localparam int P1_ALT_B_BIT = 20;
  localparam int P1_ALT_C_BIT = 19;
  localparam int P1_AUX_BIT = 18;
  localparam int P1_LOCK_RX_BIT = 17;
  localparam int P1_LOCK_TX_BIT = 16;
  localparam int HOST_MASTER_BIT = 15;
  localparam int HOST_PRI_BIT = 14;
  localparam logic [31:0] CFG_MASK = 32'h00ff_c000; // Held bits
  localparam logic [31:0] CFG_RESET = 32'h0043_4000;
  localparam logic [15:0] AUX_HI_RESET = 16'h0000;
  localparam logic [31:0] AUX_LO_RESET = 32'h0000_0000;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Fixed PTP destination addresses
  localparam logic [47:0] PRI_ADDR = 48'h01_00_5e_00_01_81;
  localparam logic [47:0] ALT_A_ADDR = 48'h01_00_5e_00_01_82;
  localparam logic [47:0] ALT_B_ADDR = 48'h01_00_5e_00_01_83;
  localparam logic [47:0] ALT_C_ADDR = 48'h01_00_5e_00_01_84;

endpackage : ptp_capture_pkg

`default_nettype wire

// ### src/ptp_capture_port_config.sv
// PTP capture configuration for port 1 and the host port, with the
// auxiliary match address, capture slots and interrupt, on AHB-Lite.
// Assumes frame events come from logic on sys_clk, one cycle each.
`default_nettype none

module ptp_capture_port_config #(
  parameter int TS_W = 32, // Width of the PTP time
  parameter logic HOST_LOCK = 1'b1 // Host port overwrite lock
) (
  input wire logic sys_clk, // Block clock
  input wire logic rst, // Asynchronous reset, high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write access
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic [TS_W-1:0] ptpTime, // Current PTP time
  input wire logic [3:0] evValid, // Frame seen, per slot
  input wire logic [3:0][47:0] evDa, // Destination, per slot
  input wire logic [3:0] evSync, // Sync message, per slot
  input wire logic [3:0] evDelayReq, // Delay_Req message, per slot
  input wire logic [3:0][15:0] evSeqId, // Sequence ID, per slot
  input wire logic [3:0][15:0] evSrcId, // Source identity, per slot
  output logic irq // Enabled capture pending
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (TS_W < 1 || TS_W > 32) begin : g_bad_width
    $error("TS_W must be 1 to 32");
  end

  typedef struct packed {
    logic [31:0] cfg;
    logic [15:0] auxHi;
    logic [31:0] auxLo;
    logic [3:0] irqEn;
    logic wrPend;
    logic [11:0] wrAddr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic irq;
  } top_state_t;

  top_state_t q; // Registered state
  top_state_t d; // Next state
  logic accept; // Address phase taken
  logic [3:0] clr; // Pending clear pulses
  logic [3:0] hit; // Qualified frames
  logic [3:0] pending; // Pending capture flags
  logic [3:0][31:0] stampW; // Captured times, word wide
  logic [3:0][31:0] tagW; // Captured IDs
  logic [3:0] priEn; // Primary enables per slot
  logic [3:0][2:0] altEn; // Alternate enables per slot
  logic [3:0] auxEn; // Auxiliary enables per slot
  logic [3:0] master; // Master role per slot
  logic [3:0] lockEn; // Lock enables per slot
  logic [47:0] auxAddr; // Joined auxiliary address
  logic [11:0] capOff; // Offset into capture window
  logic [31:0] rd; // Read mux

  ////////////////////////////////////////////////////////////////////////
  // Per-slot settings from the configuration register; host lock from HOST_LOCK
  assign auxAddr = {q.auxHi, q.auxLo};

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      priEn[i] = q.cfg[ptp_capture_pkg::P1_PRI_BIT];
      altEn[i] = {q.cfg[ptp_capture_pkg::P1_ALT_C_BIT],
                  q.cfg[ptp_capture_pkg::P1_ALT_B_BIT],
                  q.cfg[ptp_capture_pkg::P1_ALT_A_BIT]};
      auxEn[i] = q.cfg[ptp_capture_pkg::P1_AUX_BIT];
      master[i] = q.cfg[ptp_capture_pkg::P1_MASTER_BIT];
    end
    lockEn[0] = q.cfg[ptp_capture_pkg::P1_LOCK_RX_BIT];
    lockEn[1] = q.cfg[ptp_capture_pkg::P1_LOCK_TX_BIT];
    // Host port: primary address only
    for (int i = 2; i < 4; i++) begin
      priEn[i] = q.cfg[ptp_capture_pkg::HOST_PRI_BIT];
      altEn[i] = 3'h0;
      auxEn[i] = 1'b0;
      master[i] = q.cfg[ptp_capture_pkg::HOST_MASTER_BIT];
      lockEn[i] = HOST_LOCK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Filter and capture slot per port and direction
  for (genvar i = 0; i < ptp_capture_pkg::NUM_SLOTS; i++) begin : g_slot
    ptp_capture_if capIf();

    assign capIf.evValid = evValid[i];
    assign capIf.da = evDa[i];
    assign capIf.isSync = evSync[i];
    assign capIf.isDelayReq = evDelayReq[i];
    assign capIf.seqId = evSeqId[i];
    assign capIf.srcId = evSrcId[i];
    assign hit[i] = capIf.hit;

    logic [TS_W-1:0] stamp; // Slot time at its own width

    // Odd slots transmit; host slot 2 is fabric-to-host traffic
    ptp_capture_filter u_filter (
      .cap(capIf.filt),
      .priEn(priEn[i]),
      .altEn(altEn[i]),
      .auxEn(auxEn[i]),
      .auxAddr(auxAddr),
      .master(master[i]),
      .isTx(i % 2 == 1)
    );

    ptp_capture_slot #(.TS_W(TS_W)) u_slot (
      .sys_clk(sys_clk),
      .rst(rst),
      .cap(capIf.slot),
      .lockEn(lockEn[i]),
      .clr(clr[i]),
      .ptpTime(ptpTime),
      .pending(pending[i]),
      .stamp(stamp),
      .tag(tagW[i])
    );

    assign stampW[i] = 32'(stamp);
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: write data phase, then address phase with read data
  always_comb begin
    d = q;
    clr = 4'h0;
    rd = 32'h0000_0000;
    capOff = 12'h000;
    // Write data phase
    if (q.wrPend) begin
      case (q.wrAddr)
        ptp_capture_pkg::ADDR_CONFIG: begin
          d.cfg = hwdata & ptp_capture_pkg::CFG_MASK;
        end
        ptp_capture_pkg::ADDR_AUX_HI: begin
          d.auxHi = hwdata[15:0];
        end
        ptp_capture_pkg::ADDR_AUX_LO: begin
          d.auxLo = hwdata;
        end
        ptp_capture_pkg::ADDR_IRQ_EN: begin
          d.irqEn = hwdata[3:0];
        end
        ptp_capture_pkg::ADDR_IRQ_CLR: begin
          clr = hwdata[3:0];
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
    // Read mux sees a write of the previous cycle
    case (haddr[11:0])
      ptp_capture_pkg::ADDR_CONFIG: begin
        rd = d.cfg;
      end
      ptp_capture_pkg::ADDR_AUX_HI: begin
        rd = {16'h0000, d.auxHi};
      end
      ptp_capture_pkg::ADDR_AUX_LO: begin
        rd = d.auxLo;
      end
      ptp_capture_pkg::ADDR_IRQ_STS: begin
        rd = {28'h0000000, pending};
      end
      ptp_capture_pkg::ADDR_IRQ_EN: begin
        rd = {28'h0000000, d.irqEn};
      end
      default: begin
        // Capture window: time then IDs per slot
        if (haddr[11:0] >= ptp_capture_pkg::ADDR_CAP_BASE &&
            haddr[11:0] < ptp_capture_pkg::ADDR_CAP_END) begin
          capOff = haddr[11:0] - ptp_capture_pkg::ADDR_CAP_BASE;
          rd = capOff[2] ? tagW[capOff[4:3]] : stampW[capOff[4:3]];
        end
      end
    endcase
    // Address phase
    accept = hsel && htrans[1] && hready;
    d.wrPend = accept && hwrite;
    if (accept) begin
      d.wrAddr = haddr[11:0];
      d.rdata = hwrite ? 32'h0000_0000 : rd;
    end
    d.ready = 1'b1;
    d.resp = 1'b0;
    d.irq = |(pending & q.irqEn);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q.cfg <= ptp_capture_pkg::CFG_RESET;
      q.auxHi <= ptp_capture_pkg::AUX_HI_RESET;
      q.auxLo <= ptp_capture_pkg::AUX_LO_RESET;
      q.irqEn <= ptp_capture_pkg::IRQ_EN_RESET;
      q.wrPend <= 1'b0;
      q.wrAddr <= 12'h000;
      q.rdata <= 32'h0000_0000;
      q.ready <= 1'b1;
      q.resp <= 1'b0;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.ready;
  assign hresp = q.resp;
  assign hrdata = q.rdata;
  assign irq = q.irq;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Address enables gate the port 1 matches
  p1_pri_a: assert property (evValid[0] && evSync[0] &&
    evDa[0] == ptp_capture_pkg::PRI_ADDR && priEn[0] && !master[0]
    && (!lockEn[0] || !pending[0] || clr[0])
    |=> pending[0] && tagW[0] == {$past(evSeqId[0]), $past(evSrcId[0])})
    else $error("port 1 primary Sync not captured");
  p1_alt_a: assert property (hit[0] &&
    evDa[0] == ptp_capture_pkg::ALT_A_ADDR |-> q.cfg[21])
    else $error("alternate a hit while disabled");
  p1_altb_a: assert property (hit[0] &&
    evDa[0] == ptp_capture_pkg::ALT_B_ADDR |-> q.cfg[20])
    else $error("alternate b hit while disabled");
  p1_altc_a: assert property (hit[0] &&
    evDa[0] == ptp_capture_pkg::ALT_C_ADDR |-> q.cfg[19])
    else $error("alternate c hit while disabled");
  p1_aux_a: assert property (evValid[0] && evSync[0] &&
    q.cfg[18] && !q.cfg[23] && evDa[0] == {q.auxHi, q.auxLo} |-> hit[0])
    else $error("auxiliary address missed");

  // Locks keep a pending capture
  rx_lock_a: assert property (pending[0] && q.cfg[17] &&
    !clr[0] |=> $stable(stampW[0]) && $stable(tagW[0]))
    else $error("locked receive capture overwritten");
  tx_lock_a: assert property (pending[1] && q.cfg[16] &&
    !clr[1] |=> $stable(stampW[1]))
    else $error("locked transmit capture overwritten");

  // Role and direction choose the message type; host hits need the primary address
  host_role_a: assert property (hit[3] |->
    (q.cfg[15] ? evSync[3] : evDelayReq[3]))
    else $error("host transmit capture of wrong message");
  host_rx_a: assert property (hit[2] |->
    (q.cfg[15] ? evDelayReq[2] : evSync[2]))
    else $error("host receive capture of wrong message");
  host_pri_a: assert property (hit[2] || hit[3] |->
    q.cfg[14] && (!hit[2] || evDa[2] == ptp_capture_pkg::PRI_ADDR)
    && (!hit[3] || evDa[3] == ptp_capture_pkg::PRI_ADDR))
    else $error("host hit without primary enable");
  p1_role_a: assert property (hit[1] |->
    (q.cfg[23] ? evSync[1] : evDelayReq[1]))
    else $error("port 1 transmit capture of wrong message");

  // Clear racing a capture, interrupt level
  unlock_a: assert property (clr[0] && hit[0] |=>
    pending[0] && stampW[0] == 32'($past(ptpTime)))
    else $error("capture lost on clear");
  irq_lvl_a: assert property (##1 irq == |($past(pending) & $past(q.irqEn)))
    else $error("interrupt level wrong");

  // Main scenarios reached
  lock_hold_c: cover property (pending[0] && q.cfg[17] && hit[0]);
  tx_hold_c: cover property (pending[1] && q.cfg[16] && hit[1]);
  clr_race_c: cover property (clr[1] && hit[1]);
  host_cap_c: cover property (hit[2] ##[1:20] hit[3]);
  irq_c: cover property (!irq ##1 irq);

endmodule : ptp_capture_port_config

`default_nettype wire

// ### src/ptp_capture_slot.sv
// Holds the captured time, sequence ID and source identity of one port
// and direction, with its pending flag and the overwrite lock.
// Assumes clr is a one-cycle pulse from the register block.
`default_nettype none

module ptp_capture_slot #(
  parameter int TS_W = 32 // Width of the captured time
) (
  input wire logic sys_clk, // Block clock
  input wire logic rst, // Asynchronous reset, high
  ptp_capture_if.slot cap, // Qualified frame in
  input wire logic lockEn, // Keep values while pending
  input wire logic clr, // Clear pending flag
  input wire logic [TS_W-1:0] ptpTime, // Current PTP time
  output logic pending, // Capture not yet acknowledged
  output logic [TS_W-1:0] stamp, // Captured time
  output logic [31:0] tag // Sequence ID and source identity
);

  typedef struct packed {
    logic pending;
    logic [TS_W-1:0] stamp;
    logic [15:0] seqId;
    logic [15:0] srcId;
  } slot_t;

  slot_t q; // Registered state
  slot_t d; // Next state
  logic take; // Store this frame's values

  ////////////////////////////////////////////////////////////////////////
  // Capture and lock
  always_comb begin
    d = q;
    // A clear in the same cycle releases the lock at once
    take = cap.hit && !(lockEn && q.pending && !clr);
    if (take) begin
      d.stamp = ptpTime;
      d.seqId = cap.seqId;
      d.srcId = cap.srcId;
    end
    // New capture wins over a clear
    d.pending = cap.hit || (q.pending && !clr);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pending = q.pending;
  assign stamp = q.stamp;
  assign tag = {q.seqId, q.srcId};

endmodule : ptp_capture_slot

`default_nettype wire
